// ===== logic/t16c_pkg.sv
// Shared constants for the 16-bit timer with compare-output waveform stage.
// Assumes an AHB-Lite slave port, one 10 MHz clock and an active-low async reset.
// Functional notes
// - Output mode field picks next match action.
// - Reset clears the internal output bit.
// - Nonzero output mode overrides port value on pin.
// - Output mode never touches capture logic.
// - Output mode zero leaves output unchanged.
// - New output mode acts from next match.
// - Force strobe acts immediately in non-PWM modes.
// - Only waveform mode shapes the counting sequence.
// - Mode 0 counts up, wraps FFFF to 0.
// - Normal overflow flag sets when count becomes zero.
// - Overflow interrupt execution clears overflow flag.
// - Modes 4/12 clear counter at A/capture value.
// - Clear-on-compare top signalled by A or capture flag.
// - Unbuffered top below count wraps through FFFF.
// - Clear-on-compare, channel A mode 1 toggles.
// - Clear-on-compare overflow sets at MAX to zero.
// - Modes 5,6,7,14,15 are single-slope PWM.
// - PWM non-inverting sets at match, clears at bottom.
// - PWM tops: fixed, capture or A value.
// - PWM channel flag sets on every equality.
// - Compare value double buffered in PWM modes.
// - Forced compare sets no flag, keeps counter.
package t16c_pkg;
   // Register byte offsets.
   localparam logic [7:0] T16C_OFS_CTRL = 8'h00;
   localparam logic [7:0] T16C_OFS_FORCE = 8'h04;
   localparam logic [7:0] T16C_OFS_COUNT = 8'h08;
   localparam logic [7:0] T16C_OFS_CMP_A = 8'h0c;
   localparam logic [7:0] T16C_OFS_CMP_B = 8'h10;
   localparam logic [7:0] T16C_OFS_CAPT = 8'h14;
   localparam logic [7:0] T16C_OFS_FLAGS = 8'h18;
   localparam logic [7:0] T16C_OFS_PORT = 8'h1c;
   // Control register field positions.
   localparam int T16C_CTRL_MODE_LSB = 0;
   localparam int T16C_CTRL_COMA_LSB = 4;
   localparam int T16C_CTRL_COMB_LSB = 6;
   localparam int T16C_CTRL_DIV_LSB = 8;
   localparam int T16C_CTRL_RUN_BIT = 16;
   // Flag register bit positions.
   localparam int T16C_FLG_OVF = 0;
   localparam int T16C_FLG_CHA = 1;
   localparam int T16C_FLG_CHB = 2;
   localparam int T16C_FLG_CAPT = 3;
   // Port register field positions: port values in bits 1:0, directions in 3:2.
   localparam int T16C_PORT_VAL_LSB = 0;
   localparam int T16C_PORT_DIR_LSB = 2;
   // Reset values.
   localparam logic [16:0] T16C_CTRL_RST = 17'h00000;
   localparam logic [15:0] T16C_WORD_RST = 16'h0000;
   localparam logic [3:0] T16C_FLAGS_RST = 4'h0;
   localparam logic [3:0] T16C_PORT_RST = 4'h0;
   // Waveform mode codes.
   localparam logic [3:0] T16C_WGM_NORMAL = 4'h0;
   localparam logic [3:0] T16C_WGM_CTC_A = 4'h4;
   localparam logic [3:0] T16C_WGM_PWM8 = 4'h5;
   localparam logic [3:0] T16C_WGM_PWM9 = 4'h6;
   localparam logic [3:0] T16C_WGM_PWM10 = 4'h7;
   localparam logic [3:0] T16C_WGM_CTC_CAP = 4'hc;
   localparam logic [3:0] T16C_WGM_PWM_CAP = 4'he;
   localparam logic [3:0] T16C_WGM_PWM_A = 4'hf;
   // Counter limits and fixed PWM tops.
   localparam logic [15:0] T16C_MAX = 16'hffff;
   localparam logic [15:0] T16C_BOTTOM = 16'h0000;
   localparam logic [15:0] T16C_TOP8 = 16'h00ff;
   localparam logic [15:0] T16C_TOP9 = 16'h01ff;
   localparam logic [15:0] T16C_TOP10 = 16'h03ff;
   // Output mode codes.
   localparam logic [1:0] T16C_COM_OFF = 2'h0;
   localparam logic [1:0] T16C_COM_TOGGLE = 2'h1;
   localparam logic [1:0] T16C_COM_CLEAR = 2'h2;
   localparam logic [1:0] T16C_COM_SET = 2'h3;
endpackage

// ===== logic/t16c_timer.sv
// Top module: 16-bit timer with two compare channels, waveform modes and pin override.
// Assumes one AHB-Lite master with this module as its only slave, all on hclk.
// Pins leave as values and enables.
// The acknowledge comes from hclk logic.
//
// The implementer's own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module t16c_timer
   import t16c_pkg::*;
#(
   parameter int NCH = 2 // Number of compare channels; channel 0 is channel A.
) (
   input wire logic hclk, // System clock, 10 MHz.
   input wire logic hresetn, // Asynchronous reset, active low.
   input wire logic hsel, // Slave select.
   input wire logic [7:0] haddr, // Byte address.
   input wire logic [1:0] htrans, // Transfer type.
   input wire logic hwrite, // Write when high.
   input wire logic [2:0] hsize, // Transfer size, word only.
   input wire logic [31:0] hwdata, // Write data.
   input wire logic hready, // Bus ready.
   output logic [31:0] hrdata, // Read data, registered.
   output logic hreadyout, // Slave ready, registered.
   output logic hresp, // Response, always OKAY.
   input wire logic ovf_int_ack, // One-cycle pulse when the overflow interrupt executes.
   output logic [NCH-1:0] pin_o, // Pin output values.
   output logic [NCH-1:0] pin_oe // Pin output enables, high while driven.
);

   // Words by offset: control, force,
   // count, compare A and B, capture,
   // flags and port.
   // Flags clear when ones are written.
   // Unmapped words read as zero.

   // All logic runs on hclk.
   // The timer rate is a one-cycle tick.

   // Bus-side registers.
   logic [16:0] ctrl_r; // Mode, output modes, divider and run bit.
   logic [15:0] count_r; // Count register.
   logic [15:0] capt_r; // Capture value register, written by software here.
   logic [3:0] flags_r; // Sticky flags.
   logic [3:0] port_r; // Port values and pin direction bits.
   logic [7:0] presc_r; // Prescaler count.
   logic blk_r; // Blocks compare matches for one timer tick after a count write.
   logic wr_r; // Data phase of a write is pending.
   logic [7:0] addr_r; // Address of the pending write.
   logic [31:0] hrdata_r; // Registered read data.
   logic hreadyout_r; // Registered ready.
   logic [NCH-1:0] pin_o_r; // Registered pin values.
   logic [NCH-1:0] pin_oe_r; // Registered pin enables.

   // Control fields are plain slices.
   // Field decode of the control register.
   wire [3:0] mode_w = ctrl_r[T16C_CTRL_MODE_LSB +: 4];
   wire [7:0] div_w = ctrl_r[T16C_CTRL_DIV_LSB +: 8];
   wire run_w = ctrl_r[T16C_CTRL_RUN_BIT];
   wire [1:0] com_w [NCH]; // Output mode per channel.
   assign com_w[0] = ctrl_r[T16C_CTRL_COMA_LSB +: 2];
   assign com_w[1] = ctrl_r[T16C_CTRL_COMB_LSB +: 2];
   // Channel B never sets the top.
   // It follows only its own mode.

   // Unknown codes count like normal.
   // So a stray code cannot hang it.
   // The output modes never enter here.
   // Mode classes; only the waveform mode shapes counting.
   wire ctc_w = (mode_w == T16C_WGM_CTC_A) || (mode_w == T16C_WGM_CTC_CAP);
   wire pwm_w = (mode_w == T16C_WGM_PWM8) || (mode_w == T16C_WGM_PWM9) || (mode_w == T16C_WGM_PWM10)
      || (mode_w == T16C_WGM_PWM_CAP) || (mode_w == T16C_WGM_PWM_A);
   wire cap_top_w = (mode_w == T16C_WGM_CTC_CAP) || (mode_w == T16C_WGM_PWM_CAP);

   // Writes are posted to the data phase.
   // The address waits one cycle in a flop.
   // A read right after a write to the
   // same word sees the older value.
   // Software must leave one idle cycle.
   // Bus decode: address phase accepted, and writes landing in their data phase.
   wire acc_w = hsel && htrans[1] && hready;
   wire wr_ctrl_w = wr_r && (addr_r == T16C_OFS_CTRL);
   wire wr_force_w = wr_r && (addr_r == T16C_OFS_FORCE);
   wire wr_count_w = wr_r && (addr_r == T16C_OFS_COUNT);
   wire wr_capt_w = wr_r && (addr_r == T16C_OFS_CAPT);
   wire wr_flags_w = wr_r && (addr_r == T16C_OFS_FLAGS);
   wire wr_port_w = wr_r && (addr_r == T16C_OFS_PORT);
   wire [NCH-1:0] wr_cmp_w;
   assign wr_cmp_w[0] = wr_r && (addr_r == T16C_OFS_CMP_A);
   assign wr_cmp_w[1] = wr_r && (addr_r == T16C_OFS_CMP_B);

   // A divider of zero ticks every clock.
   // Run low clears the prescaler.
   // So a restart gets a whole period.
   // There is no second clock to cross.
   // Timer clock enable from the prescaler; one pulse every div+1 system clocks.
   wire tick_w = run_w && (presc_r == div_w);

   // Shared logic reads these results.
   // Per-channel outputs of the generate loop.
   logic [15:0] cmp_act_w [NCH]; // Active compare values.
   logic [15:0] cmp_buf_w [NCH]; // Software-visible compare values.
   logic [NCH-1:0] match_w; // One pulse per equality on a timer tick.
   logic [NCH-1:0] out_bit_w; // Internal compare output bits.

   // Channel A tops use the active value.
   // In PWM it moves only at top.
   // So a PWM period with an A top never changes midway.
   // The capture top is unbuffered.
   // Top selection: fixed, capture register or channel A compare value.
   wire [15:0] top_w = (mode_w == T16C_WGM_PWM8) ? T16C_TOP8 :
                       (mode_w == T16C_WGM_PWM9) ? T16C_TOP9 :
                       (mode_w == T16C_WGM_PWM10) ? T16C_TOP10 :
                       cap_top_w ? capt_r :
                       (ctc_w || pwm_w) ? cmp_act_w[0] : T16C_MAX;

   // A top write below the count is simply missed; the count runs on to FFFF.
   wire top_hit_w = tick_w && !blk_r && (ctc_w || pwm_w) && (count_r == top_w);
   wire max_w = tick_w && (count_r == T16C_MAX);

   // A software write beats counting.
   // A tick in that cycle is lost.
   // Software should write while stopped.
   // Next count: software write wins, else clear at top or increment with wrap.
   wire [15:0] count_nxt = wr_count_w ? hwdata[15:0] :
                           !tick_w ? count_r :
                           top_hit_w ? T16C_BOTTOM : 16'(count_r + 16'h0001);

   // In PWM the wrap comes at top.
   // Overflow then marks each period.
   // Only a written one or ovf_int_ack clears this flag.
   // Overflow: at MAX to zero in normal and CLEAR_ON_COMPARE_MODE, at top in PWM.
   wire ovf_set_w = pwm_w ? top_hit_w : max_w;

   // Capture flag marks top when the capture register defines it.
   wire capt_set_w = top_hit_w && cap_top_w;
   wire [3:0] flag_set_w = {capt_set_w, match_w[1], match_w[0], ovf_set_w};
   wire [3:0] flag_clr_w = (wr_flags_w ? hwdata[3:0] : 4'h0) | {3'h0, ovf_int_ack};

   // A set in the same cycle as a clear wins, so no event is lost.
   wire [3:0] flags_nxt = (flags_r & ~flag_clr_w) | flag_set_w;

   // The mux looks at the address phase.
   // The word stands when data opens.
   // Upper bits always read as zero.
   // Read mux for the address phase; unmapped words read as zero.
   wire [31:0] rd_w = (haddr == T16C_OFS_CTRL) ? {15'h0000, ctrl_r} :
                      (haddr == T16C_OFS_COUNT) ? {16'h0000, count_r} :
                      (haddr == T16C_OFS_CMP_A) ? {16'h0000, cmp_buf_w[0]} :
                      (haddr == T16C_OFS_CMP_B) ? {16'h0000, cmp_buf_w[1]} :
                      (haddr == T16C_OFS_CAPT) ? {16'h0000, capt_r} :
                      (haddr == T16C_OFS_FLAGS) ? {28'h0000000, flags_r} :
                      (haddr == T16C_OFS_PORT) ? {28'h0000000, port_r} : 32'h00000000;

   // Ready is low only during reset.
   // No transfer is ever stretched.
   // The answer is always OKAY.
   // Bus slave: zero wait states, reads registered in the address phase.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_r <= 1'b0;
         addr_r <= 8'h00;
         hrdata_r <= 32'h00000000;
         hreadyout_r <= 1'b0;
      end else begin
         wr_r <= acc_w && hwrite;
         addr_r <= acc_w ? haddr : addr_r;
         hrdata_r <= (acc_w && !hwrite) ? rd_w : hrdata_r;
         hreadyout_r <= 1'b1;
      end
   end

   // Unmapped writes are dropped.
   // The force word keeps no state.
   // Size is not checked; words only.
   // Software-written registers.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r <= T16C_CTRL_RST;
         capt_r <= T16C_WORD_RST;
         port_r <= T16C_PORT_RST;
      end else begin
         ctrl_r <= wr_ctrl_w ? hwdata[16:0] : ctrl_r;
         capt_r <= wr_capt_w ? hwdata[15:0] : capt_r;
         port_r <= wr_port_w ? hwdata[3:0] : port_r;
      end
   end

   // The block holds until a tick passes.
   // A stopped timer drops the next match.
   // Equal count and compare stay quiet.
   // Counter, prescaler, flags and the match block after a count write.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_r <= T16C_WORD_RST;
         presc_r <= 8'h00;
         flags_r <= T16C_FLAGS_RST;
         blk_r <= 1'b0;
      end else begin
         count_r <= count_nxt;
         presc_r <= (!run_w || tick_w) ? 8'h00 : 8'(presc_r + 8'h01);
         flags_r <= flags_nxt;
         blk_r <= wr_count_w ? 1'b1 : (tick_w ? 1'b0 : blk_r);
      end
   end

   // Each channel owns its buffer.
   // One loop keeps them all alike.
   // Channel 0 is the top channel.
   // One instance of compare logic per channel.
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      logic [15:0] buf_r; // Buffer written by software.
      logic [15:0] act_r; // Value the comparator uses.
      logic out_r; // Internal compare output bit.
      logic act_match; // Action event for the output bit.
      logic out_nxt; // Next output bit.
      logic pin_r; // Registered pin value.
      logic pen_r; // Registered pin enable.

      // Match on every timer tick while not blocked.
      wire mt = tick_w && !blk_r && (count_r == act_r);

      // Force works only outside PWM and never touches flags or counter.
      wire frc = wr_force_w && hwdata[i] && !pwm_w;

      // Channel A toggle in PWM exists only when A defines top.
      wire pwm_tog = (i == 0) && (mode_w == T16C_WGM_PWM_A);

      // The bit moves on a match or force.
      // In PWM it also moves at top.
      // Nothing else ever touches it.
      // Output action uses the current mode field, so a new value acts at the next match.
      always_comb begin
         act_match = mt || frc;
         out_nxt = out_r;
         // Outside PWM a match or force acts.
         if (!pwm_w) begin
            if (act_match) begin
               unique case (com_w[i])
                  T16C_COM_OFF: out_nxt = out_r;
                  T16C_COM_TOGGLE: out_nxt = !out_r;
                  T16C_COM_CLEAR: out_nxt = 1'b0;
                  T16C_COM_SET: out_nxt = 1'b1;
               endcase
            end
         end else begin
            // Match has priority over bottom so that compare equal to top gives a steady level.
            unique case (com_w[i])
               T16C_COM_OFF: out_nxt = out_r;
               T16C_COM_TOGGLE: out_nxt = (mt && pwm_tog) ? !out_r : out_r;
               T16C_COM_CLEAR: out_nxt = mt ? 1'b1 : (top_hit_w ? 1'b0 : out_r);
               T16C_COM_SET: out_nxt = mt ? 1'b0 : (top_hit_w ? 1'b1 : out_r);
            endcase
         end
      end

      // A compare read gives the buffer.
      // That is the value last written.
      // Fixed tops do not mask the word.
      // Compare storage: buffered in PWM and loaded at top, direct otherwise.
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            buf_r <= T16C_WORD_RST;
            act_r <= T16C_WORD_RST;
            out_r <= 1'b0;
         end else begin
            buf_r <= wr_cmp_w[i] ? hwdata[15:0] : buf_r;
            if (wr_cmp_w[i] && !pwm_w) begin
               act_r <= hwdata[15:0];
            end else if (pwm_w && top_hit_w) begin
               act_r <= buf_r;
            end
            out_r <= out_nxt;
         end
      end

      // Pin: output mode nonzero takes over the port value; direction stays with software.
      always_ff @(posedge hclk or negedge hresetn) begin
         // Each flop lives in this one process.
         if (!hresetn) begin
            pin_r <= 1'b0;
            pen_r <= 1'b0;
         end else begin
            pin_r <= (com_w[i] != T16C_COM_OFF) ? out_nxt : port_r[T16C_PORT_VAL_LSB + i];
            pen_r <= port_r[T16C_PORT_DIR_LSB + i];
         end
      end

      assign cmp_act_w[i] = act_r;
      assign cmp_buf_w[i] = buf_r;
      assign match_w[i] = mt;
      assign out_bit_w[i] = out_r;
      // Whole-bit copies of the pin flops.
      assign pin_o_r[i] = pin_r;
      assign pin_oe_r[i] = pen_r;
   end

   // Top outputs are the flops above; hresp is tied low.
   // Capture logic is out of this block; the output mode field never reaches it.
   assign hrdata = hrdata_r;
   assign hreadyout = hreadyout_r;
   assign hresp = 1'b0;
   assign pin_o = pin_o_r;
   assign pin_oe = pin_oe_r;

   // All checks share one clock.
   // They rest while reset is low.
   // Of the bus inputs they look only at hwdata.
   // Checks on the counting and output behaviour.
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_normal_wrap: assert property ((mode_w == T16C_WGM_NORMAL) && max_w && !wr_count_w
      |=> count_r == T16C_BOTTOM) else $error("Normal mode did not wrap to zero.");

   a_ovf_on_wrap: assert property ((mode_w == T16C_WGM_NORMAL) && max_w
      |=> flags_r[T16C_FLG_OVF] && (count_r == T16C_BOTTOM || $past(wr_count_w)))
      else $error("Overflow flag not set on wrap.");

   a_ovf_sticky: assert property (flags_r[T16C_FLG_OVF] && !ovf_int_ack
      && !(wr_flags_w && hwdata[T16C_FLG_OVF]) |=> flags_r[T16C_FLG_OVF])
      else $error("Overflow flag dropped without a clear.");

   a_ack_clears: assert property (ovf_int_ack && !ovf_set_w |=> !flags_r[T16C_FLG_OVF])
      else $error("Interrupt acknowledge did not clear overflow.");

   a_ctc_clear: assert property (tick_w && !blk_r && (mode_w == T16C_WGM_CTC_A)
      && (count_r == cmp_act_w[0]) && !wr_count_w |=> (count_r == T16C_BOTTOM) && flags_r[T16C_FLG_CHA])
      else $error("Clear-on-compare did not clear counter.");

   a_ctc_toggle: assert property ((mode_w == T16C_WGM_CTC_A) && (com_w[0] == T16C_COM_TOGGLE)
      && match_w[0] |=> out_bit_w[0] != $past(out_bit_w[0])) else $error("Channel A did not toggle.");

   a_pwm_set: assert property (pwm_w && (com_w[0] == T16C_COM_CLEAR) && match_w[0]
      |=> out_bit_w[0]) else $error("Non-inverting PWM did not set on match.");

   a_force_out: assert property (wr_force_w && hwdata[0] && !pwm_w && (com_w[0] == T16C_COM_SET)
      |=> out_bit_w[0]) else $error("Force did not set output.");

   a_force_noflag: assert property (wr_force_w && !tick_w && !wr_flags_w && !wr_count_w && !ovf_int_ack
      |=> $stable(flags_r) && $stable(count_r)) else $error("Force changed flags or counter.");

   a_off_holds: assert property (com_w[0] == T16C_COM_OFF |=> $stable(out_bit_w[0]))
      else $error("Output changed with mode off.");

   a_pin_override: assert property (com_w[1] != T16C_COM_OFF |=> pin_o[1] == out_bit_w[1])
      else $error("Pin not driven by compare output.");

   // Channel A pin follows its bit too.
   a_pin_override_a: assert property (com_w[0] != T16C_COM_OFF |=> pin_o[0] == out_bit_w[0])
      else $error("Pin A not driven by compare output.");
   // Non-inverting PWM clears at bottom.
   a_pwm_bottom: assert property (pwm_w && (com_w[0] == T16C_COM_CLEAR) && top_hit_w && !match_w[0]
      |=> !out_bit_w[0]) else $error("PWM output not cleared at bottom.");
   // The active compare waits for top.
   a_pwm_buffer: assert property (pwm_w && !top_hit_w |=> $stable(cmp_act_w[0]))
      else $error("Active compare changed away from top.");
   // Capture flag marks a capture top.
   a_top_capture: assert property (cap_top_w && top_hit_w |=> flags_r[T16C_FLG_CAPT])
      else $error("Capture flag not set at top.");

   c_ctc_toggle: cover property ((mode_w == T16C_WGM_CTC_A) && match_w[0] && (com_w[0] == T16C_COM_TOGGLE));
   c_pwm_top: cover property (pwm_w && top_hit_w);
   c_force: cover property (wr_force_w && !pwm_w && (com_w[0] != T16C_COM_OFF));
   c_overflow: cover property (ovf_set_w && (mode_w == T16C_WGM_NORMAL));
   // Inverting PWM reaching its match.
   c_pwm_inv: cover property (pwm_w && (com_w[0] == T16C_COM_SET) && match_w[0]);

endmodule

// ===== verification/t16c_pin_load.sv
// Far-side model: the two compare output pins and their external load.
// Assumes pin_o and pin_oe come straight from the timer top module.
`timescale 1ns/1ps
module t16c_pin_load (
   input wire logic [1:0] pin_o, // Values driven by the timer.
   input wire logic [1:0] pin_oe, // Enables, high while the timer drives.
   output logic [1:0] pad // Level seen on each wire.
);
   // A pull-up holds a released wire high, so a stale driven value never shows on an idle pin.
   assign pad = (pin_oe & pin_o) | ~pin_oe;
endmodule

// ===== verification/timer16_compare_output_modes_tb.sv
// Self-checking bench for the 16-bit timer compare-output stage.
// Assumes the timer package, the timer top and the pin load model are compiled first.
`timescale 1ns/1ps
module timer16_compare_output_modes_tb;
   import t16c_pkg::*;
   typedef struct packed {
      logic [3:0] mode; // Waveform mode.
      logic [15:0] cmp; // Channel A compare value.
      logic [15:0] cap; // Capture value register.
      logic [15:0] start; // Count loaded before the run.
      logic [3:0] flags; // Expected flags, channel B ignored.
      logic wrap; // Counter expected to pass bottom.
   } t16c_row_type;
   localparam logic [31:0] RUN = 32'h00010000; // Run bit of the control word.
   logic hclk = 1'b0; // System clock.
   logic hresetn = 1'b0; // Reset, active low.
   logic hsel = 1'b0; // Slave select.
   logic [7:0] haddr = 8'h00; // Byte address.
   logic [1:0] htrans = 2'h0; // Transfer type.
   logic hwrite = 1'b0; // Write when high.
   logic [31:0] hwdata = 32'h00000000; // Write data.
   logic ovf_ack = 1'b0; // Overflow interrupt taken.
   logic [31:0] hrdata; // Read data.
   logic hreadyout; // Slave ready, fed back as bus ready.
   logic hresp; // Response code.
   logic [1:0] pin_o; // Pin values.
   logic [1:0] pin_oe; // Pin enables.
   logic [1:0] pad; // Wire levels.
   int err_count = 0; // Mismatches seen.
   int check_count = 0; // Comparisons made.
   int cyc = 0; // Cycles run, for the timeout.
   int hi; // High or toggle count on pin A.
   logic [31:0] rd; // Last word read.
   logic last; // Previous pin A level.
   // Mode cases: start counts just below top, except two clear-on-compare rows that start above it.
   t16c_row_type rows[9] = '{
      {T16C_WGM_NORMAL, 16'h8000, 16'h0000, 16'hfffd, 4'h1, 1'b1},
      {T16C_WGM_CTC_A, 16'h0100, 16'h0000, 16'h00fd, 4'h2, 1'b1},
      {T16C_WGM_CTC_CAP, 16'h8000, 16'h0005, 16'hfffd, 4'h9, 1'b1},
      {T16C_WGM_CTC_A, 16'h0010, 16'h0000, 16'h0020, 4'h0, 1'b0},
      {T16C_WGM_PWM8, 16'h8000, 16'h0000, 16'h00fc, 4'h1, 1'b1},
      {T16C_WGM_PWM9, 16'h8000, 16'h0000, 16'h01fc, 4'h1, 1'b1},
      {T16C_WGM_PWM10, 16'h8000, 16'h0000, 16'h03fc, 4'h1, 1'b1},
      {T16C_WGM_PWM_CAP, 16'h8000, 16'h0040, 16'h003c, 4'h9, 1'b1},
      {T16C_WGM_PWM_A, 16'h0040, 16'h0000, 16'h003c, 4'h3, 1'b1}};
   // Forced-compare steps: output mode, force strobe, expected pin level.
   logic [3:0] steps[8] = '{4'h4, 4'hf, 4'h2, 4'h5, 4'h6, 4'ha, 4'hf, 4'ha};

   t16c_timer DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .ovf_int_ack(ovf_ack), .pin_o(pin_o), .pin_oe(pin_oe));
   t16c_pin_load load (.pin_o(pin_o), .pin_oe(pin_oe), .pad(pad));

   // Free-running 10 MHz clock.
   initial begin
      forever #50 hclk = ~hclk;
   end

   // Prints the counts and the verdict, then stops.
   task automatic finish_test();
      $display("checks %0d, errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Compares one value with its expectation.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One single AHB-Lite transfer; read data lands in rd at the data-phase edge.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   // Cuts a hang short; the whole run needs well under this many cycles.
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         finish_test();
      end
   end

   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check(pin_o, 2'h0);
      check(hresp, 1'b0);
      // Every register and two unmapped words read zero after reset, one of them after a write.
      bus(1'b1, 8'h24, 32'hffffffff);
      for (int a = 0; a <= 36; a += 4) begin
         bus(1'b0, 8'(a), 32'h0);
         check(rd, 32'h0);
      end
      // Each row from its start count, below or above top: flags and wrap tell how it counted.
      foreach (rows[i]) begin
         bus(1'b1, T16C_OFS_CTRL, 32'h0);
         bus(1'b1, T16C_OFS_CMP_A, 32'(rows[i].cmp));
         bus(1'b1, T16C_OFS_CAPT, 32'(rows[i].cap));
         bus(1'b1, T16C_OFS_COUNT, 32'(rows[i].start));
         bus(1'b1, T16C_OFS_FLAGS, 32'hf);
         bus(1'b1, T16C_OFS_CTRL, RUN | 32'(rows[i].mode));
         repeat (20) @(posedge hclk);
         bus(1'b1, T16C_OFS_CTRL, 32'(rows[i].mode));
         bus(1'b0, T16C_OFS_FLAGS, 32'h0);
         check(rd & 32'hb, 32'(rows[i].flags));
         bus(1'b0, T16C_OFS_COUNT, 32'h0);
         check(32'(rd < 32'h20), 32'(rows[i].wrap));
      end
      // Pins released: the pull-up shows until software sets the directions.
      bus(1'b1, T16C_OFS_CTRL, 32'h0);
      check(pad, 2'h3);
      bus(1'b1, T16C_OFS_PORT, 32'hc);
      bus(1'b1, T16C_OFS_COUNT, 32'h1234);
      check(pad, 2'h0);
      bus(1'b1, T16C_OFS_FLAGS, 32'hf);
      // Output bit stayed 0 through earlier matches; forced actions then act at once.
      foreach (steps[i]) begin
         bus(1'b1, T16C_OFS_CTRL, 32'(steps[i][3:2]) << 4);
         if (steps[i][1]) begin
            bus(1'b1, T16C_OFS_FORCE, 32'h1);
         end
         repeat (2) @(posedge hclk);
         check(pad[0], steps[i][0]);
      end
      bus(1'b0, T16C_OFS_COUNT, 32'h0);
      check(rd, 32'h1234);
      bus(1'b0, T16C_OFS_FLAGS, 32'h0);
      check(rd, 32'h0);
      // Clear-on-compare toggle: top 4 gives one edge every five clocks.
      bus(1'b1, T16C_OFS_CMP_A, 32'h4);
      bus(1'b1, T16C_OFS_COUNT, 32'h0);
      bus(1'b1, T16C_OFS_CTRL, RUN | 32'h10 | 32'(T16C_WGM_CTC_A));
      hi = 0;
      last = pad[0];
      repeat (60) begin
         @(posedge hclk);
         #1;
         if (pad[0] !== last) hi++;
         last = pad[0];
      end
      check(32'(hi >= 11 && hi <= 13), 32'h1);
      // Single-slope PWM at top 0xff, compare 0x40, both polarities.
      for (int c = 2; c <= 3; c++) begin
         bus(1'b1, T16C_OFS_CTRL, 32'h0);
         bus(1'b1, T16C_OFS_CMP_A, 32'h40);
         bus(1'b1, T16C_OFS_FLAGS, 32'hf);
         bus(1'b1, T16C_OFS_CTRL, RUN | (32'(c) << 4) | 32'(T16C_WGM_PWM8));
         repeat (256) @(posedge hclk);
         hi = 0;
         repeat (512) begin
            @(posedge hclk);
            if (pad[0] === 1'b1) hi++;
         end
         check(32'(hi > ((c == 2) ? 378 : 126) && hi < ((c == 2) ? 386 : 134)), 32'h1);
      end
      bus(1'b1, T16C_OFS_CTRL, 32'(T16C_WGM_PWM8));
      bus(1'b0, T16C_OFS_FLAGS, 32'h0);
      check(rd & 32'h3, 32'h3);
      // The interrupt acknowledge clears only the overflow flag.
      @(posedge hclk);
      ovf_ack <= 1'b1;
      @(posedge hclk);
      ovf_ack <= 1'b0;
      bus(1'b0, T16C_OFS_FLAGS, 32'h0);
      check(rd & 32'h3, 32'h2);
      finish_test();
   end
endmodule
